// ### inc/rtc_pkg.sv
/*
 Constants shared by the transmitter control register bank and its lock monitor.
 Assumes a 6-bit processor I/O address and 8-bit I/O data.
*/
package rtc_pkg;
   // I/O addresses
   localparam logic [5:0] OFF_CFG_A = 6'h10;
   localparam logic [5:0] OFF_TX = 6'h12;
   localparam logic [5:0] OFF_ATT = 6'h14;
   localparam logic [5:0] OFF_VCO = 6'h16;
   localparam logic [5:0] OFF_CFG_B = 6'h17;
   localparam logic [5:0] BIT_ACCESS_LIMIT = 6'h20;
   // lock_monitor_config_a fields
   localparam int CA_HOLD = 4;
   localparam int CA_KBE = 3;
   localparam int CA_BOD = 2;
   localparam int CA_LIM = 0;
   // transmit_control fields
   localparam int TX_ON = 5;
   localparam int TX_KEY = 4;
   localparam int TX_LOCK = 2;
   // output_attenuation fields
   localparam int AT_COARSE = 3;
   localparam int AT_FINE = 0;
   // vco_trim fields
   localparam int VC_WIN = 6;
   localparam int VC_SPARE = 5;
   localparam int VC_CAP = 0;
   // lock_monitor_config_b fields
   localparam int CB_UDE = 7;
   localparam int CB_FORCE = 6;
   localparam int CB_BOL = 3;
   localparam int CB_LKL = 0;
   // Reset values
   localparam logic [7:0] RST_CFG_A = 8'h00;
   localparam logic [7:0] RST_TX = 8'h00;
   localparam logic [7:0] RST_ATT = 8'h00;
   localparam logic [7:0] RST_VCO = 8'h00;
   localparam logic [7:0] RST_CFG_B = 8'h00;
   // Coarse attenuation step in dB
   localparam logic [5:0] COARSE_STEP_DB = 6'h06;
   // Shortest blackout or lock delay, in reference clocks
   localparam logic [10:0] REF_BASE_CLKS = 11'h008;

   // Reference clocks for a 3-bit length code: 8 doubling up to 1024
   function automatic logic [10:0] ref_len(input logic [2:0] code);
      return REF_BASE_CLKS << code;
   endfunction
endpackage

// ### inc/rtc_lock_if.sv
/*
 Carrier between the register bank and the lock monitor.
 Assumes both ends sit on the same clock.
*/
interface rtc_lock_if;
   logic hold;
   logic key_bo_en;
   logic bo_dis;
   logic [1:0] slip_lim;
   logic ud_en;
   logic [2:0] bo_len;
   logic [2:0] lk_len;
   logic tx_en;
   logic key;
   logic ref_tick;
   logic slip_tick;
   logic lock;
   logic bo_done;
   logic count_ok;
   modport mon (
      input hold, key_bo_en, bo_dis, slip_lim, ud_en, bo_len, lk_len,
      input tx_en, key, ref_tick, slip_tick,
      output lock, bo_done, count_ok
   );
   modport regs (
      output hold, key_bo_en, bo_dis, slip_lim, ud_en, bo_len, lk_len,
      output tx_en, key, ref_tick, slip_tick,
      input lock, bo_done, count_ok
   );
endinterface

// ### rtl/rtc_lock_mon.sv
/*
 Lock monitor: lock delay counter, blackout window and cycle-slip counter.
 Assumes reference and slip ticks are one-cycle pulses on the system clock.
*/
module rtc_lock_mon (
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Register side
   rtc_lock_if.mon lk
);
   logic key_prev_q;
   logic lock_prev_q;
   logic lock_q;
   logic bo_done_q;
   logic [10:0] bo_cnt_q;
   logic [10:0] lk_cnt_q;
   logic [2:0] slip_cnt_q;
   logic bo_rst;
   logic count_ok;
   logic slip_hit;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         key_prev_q <= 1'b0;
         lock_prev_q <= 1'b0;
      end else begin
         key_prev_q <= lk.key;
         lock_prev_q <= lock_q;
      end
   end

   // Hold level, key rise (when key_bo_en) and lock rise all restart the blackout
   assign bo_rst = lk.hold | (lk.key_bo_en & lk.key & ~key_prev_q)
      | (lock_q & ~lock_prev_q);
   // A blackout restarted in this cycle already masks the slip that arrives with it
   assign count_ok = ~lk.hold & lk.ud_en & lock_q
      & (lk.bo_dis | (bo_done_q & ~bo_rst));
   assign slip_hit = lk.slip_tick & count_ok;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         bo_cnt_q <= 11'h000;
         bo_done_q <= 1'b0;
      end else if (bo_rst) begin
         bo_cnt_q <= 11'h000;
         bo_done_q <= 1'b0;
      end else if (lk.ref_tick && !bo_done_q) begin
         bo_cnt_q <= bo_cnt_q + 11'h001;
         if (bo_cnt_q + 11'h001 == rtc_pkg::ref_len(lk.bo_len)) begin
            bo_done_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         slip_cnt_q <= 3'h0;
      end else if (bo_rst || !lock_q) begin
         slip_cnt_q <= 3'h0;
      end else if (slip_hit) begin
         slip_cnt_q <= slip_cnt_q + 3'h1;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         lk_cnt_q <= 11'h000;
      end else if (!lk.tx_en || lk.slip_tick || lock_q) begin
         lk_cnt_q <= 11'h000;
      end else if (lk.ref_tick) begin
         lk_cnt_q <= lk_cnt_q + 11'h001;
      end
   end

   // Unlock outranks a lock that completes in the same cycle
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         lock_q <= 1'b0;
      end else if (!lk.tx_en) begin
         lock_q <= 1'b0;
      end else if (slip_hit && slip_cnt_q == {1'b0, lk.slip_lim}) begin
         lock_q <= 1'b0;
      end else if (!lock_q && lk.ref_tick && !lk.slip_tick
                   && lk_cnt_q + 11'h001 == rtc_pkg::ref_len(lk.lk_len)) begin
         lock_q <= 1'b1;
      end
   end

   assign lk.lock = lock_q;
   assign lk.bo_done = bo_done_q;
   assign lk.count_ok = count_ok;
endmodule // rtc_lock_mon

// ### rtl/rtc_tx_regs.sv
/*
 Transmitter control register bank on the processor I/O port, with pin
 synchronisers and the lock monitor instance.
 Assumes reference clock and slip pins are slower than a quarter of clock.
*/
// Function
// - unlock_hold high keeps unlock counter reset
// - Key rise starts blackout when enabled
// - blackout_disable counts slips at once, locked only
// - slip_limit code plus one slips drops lock
// - No slip counting before blackout ends
// - transmitter_on bit switches transmitter
// - Carrier key is manual_key OR bit timer
// - synth_locked read-only bit shows lock
// - Attenuation equals coarse plus fine
// - Coarse attenuation in 6 dB steps
// - Fine attenuation in 1 dB steps
// - VCO capacitor trim follows 5-bit code
// - VCO window bits read-only, bit 5 RW
// - Single-bit set and clear below 0x20
// - Registers decoded at 0x10,12,14,16,17
// - Config A resets to zero, top reserved
// - Blackout length 8 to 1024 reference clocks
// - Unlock counter reset by key, lock, hold
// - Lock rises after delay, restarts on slip
module rtc_tx_regs (
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Processor I/O port
   input wire logic [5:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   input wire logic io_bit_set,
   input wire logic io_bit_clr,
   input wire logic [2:0] io_bit_idx,
   output logic [7:0] io_rdata_q,
   // Synthesizer pins
   input wire logic ref_clk_pin,
   input wire logic slip_pin,
   input wire logic [1:0] vco_window_pin,
   // Bit timer
   input wire logic bit_timer_key,
   // Transmitter controls
   output logic tx_enable_q,
   output logic carrier_key_q,
   output logic [5:0] atten_db_q,
   output logic [4:0] vco_cap_q,
   output logic lock_ind_q
);
   localparam int NPIN = 4;

   logic [4:0] cfg_a_q;
   logic manual_key_q;
   logic [5:0] att_q;
   logic vco_spare_q;
   logic [7:0] cfg_b_q;
   logic [NPIN-1:0] s1_q;
   logic [NPIN-1:0] s2_q;
   logic [NPIN-1:0] s3_q;
   logic [NPIN-1:0] filt_q;
   logic [NPIN-1:0] filt_prev_q;
   logic [NPIN-1:0] pins;
   logic [7:0] bit_mask;
   logic [7:0] cur_a;
   logic [7:0] cur_tx;
   logic [7:0] cur_att;
   logic [7:0] cur_vco;
   logic [7:0] cur_b;
   logic [7:0] nxt_a;
   logic [7:0] nxt_tx;
   logic [7:0] nxt_att;
   logic [7:0] nxt_vco;
   logic [7:0] nxt_b;
   logic [7:0] rd_val;
   logic [5:0] coarse_db;

   rtc_lock_if lk ();

   function automatic logic sel(input logic [5:0] addr, input logic [5:0] off);
      return addr == off;
   endfunction

   // Byte write wins over a bit instruction issued in the same cycle
   function automatic logic [7:0] nxt(
      input logic [7:0] old,
      input logic [5:0] off,
      input logic [5:0] addr,
      input logic wr,
      input logic st,
      input logic cl,
      input logic [7:0] msk,
      input logic [7:0] wd
   );
      logic hit;
      logic bit_ok;
      hit = sel(addr, off);
      bit_ok = hit && (addr < rtc_pkg::BIT_ACCESS_LIMIT);
      if (wr && hit) begin
         return wd;
      end else if (st && bit_ok) begin
         return old | msk;
      end else if (cl && bit_ok) begin
         return old & ~msk;
      end else begin
         return old;
      end
   endfunction

   assign pins = {vco_window_pin, slip_pin, ref_clk_pin};

   // A pin change is taken only once stages two and three agree
   generate
      for (genvar i = 0; i < NPIN; i++) begin : g_sync
         always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
               s1_q[i] <= 1'b0;
               s2_q[i] <= 1'b0;
               s3_q[i] <= 1'b0;
               filt_q[i] <= 1'b0;
               filt_prev_q[i] <= 1'b0;
            end else begin
               s1_q[i] <= pins[i];
               s2_q[i] <= s1_q[i];
               s3_q[i] <= s2_q[i];
               if (s2_q[i] == s3_q[i]) begin
                  filt_q[i] <= s3_q[i];
               end
               filt_prev_q[i] <= filt_q[i];
            end
         end
      end
   endgenerate

   assign bit_mask = 8'h01 << io_bit_idx;

   // Current register images; reserved bits read as zero
   assign cur_a = {3'h0, cfg_a_q};
   assign cur_tx = {2'h0, tx_enable_q, manual_key_q, 1'b0, lock_ind_q, 2'h0};
   assign cur_att = {2'h0, att_q};
   assign cur_vco = {filt_q[3:2], vco_spare_q, vco_cap_q};
   assign cur_b = cfg_b_q;

   assign nxt_a = nxt(cur_a, rtc_pkg::OFF_CFG_A, io_addr, io_wr,
                      io_bit_set, io_bit_clr, bit_mask, io_wdata);
   assign nxt_tx = nxt(cur_tx, rtc_pkg::OFF_TX, io_addr, io_wr,
                       io_bit_set, io_bit_clr, bit_mask, io_wdata);
   assign nxt_att = nxt(cur_att, rtc_pkg::OFF_ATT, io_addr, io_wr,
                        io_bit_set, io_bit_clr, bit_mask, io_wdata);
   assign nxt_vco = nxt(cur_vco, rtc_pkg::OFF_VCO, io_addr, io_wr,
                        io_bit_set, io_bit_clr, bit_mask, io_wdata);
   assign nxt_b = nxt(cur_b, rtc_pkg::OFF_CFG_B, io_addr, io_wr,
                      io_bit_set, io_bit_clr, bit_mask, io_wdata);

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cfg_a_q <= rtc_pkg::RST_CFG_A[4:0];
      end else begin
         cfg_a_q <= nxt_a[4:0];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         tx_enable_q <= rtc_pkg::RST_TX[rtc_pkg::TX_ON];
         manual_key_q <= rtc_pkg::RST_TX[rtc_pkg::TX_KEY];
      end else begin
         tx_enable_q <= nxt_tx[rtc_pkg::TX_ON];
         manual_key_q <= nxt_tx[rtc_pkg::TX_KEY];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         att_q <= rtc_pkg::RST_ATT[5:0];
      end else begin
         att_q <= nxt_att[5:0];
      end
   end

   // Window state bits are not stored: they come from the comparator pins
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         vco_spare_q <= rtc_pkg::RST_VCO[rtc_pkg::VC_SPARE];
         vco_cap_q <= rtc_pkg::RST_VCO[4:0];
      end else begin
         vco_spare_q <= nxt_vco[rtc_pkg::VC_SPARE];
         vco_cap_q <= nxt_vco[4:0];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cfg_b_q <= rtc_pkg::RST_CFG_B;
      end else begin
         cfg_b_q <= nxt_b;
      end
   end

   // Manual key is ORed in; software clears it when the timer keys
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         carrier_key_q <= 1'b0;
      end else begin
         carrier_key_q <= manual_key_q | bit_timer_key;
      end
   end

   // Invalid codes 110 and 111 are not clamped; they just add up
   assign coarse_db = 6'(att_q[5:3] * rtc_pkg::COARSE_STEP_DB);

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         atten_db_q <= 6'h00;
      end else begin
         atten_db_q <= coarse_db + {3'h0, att_q[2:0]};
      end
   end

   // Forced lock only affects lock_ind_q; the monitor's own lock is untouched
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         lock_ind_q <= 1'b0;
      end else begin
         lock_ind_q <= lk.lock | cfg_b_q[rtc_pkg::CB_FORCE];
      end
   end

   always_comb begin
      case (io_addr)
         rtc_pkg::OFF_CFG_A: rd_val = cur_a;
         rtc_pkg::OFF_TX: rd_val = cur_tx;
         rtc_pkg::OFF_ATT: rd_val = cur_att;
         rtc_pkg::OFF_VCO: rd_val = cur_vco;
         rtc_pkg::OFF_CFG_B: rd_val = cur_b;
         default: rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         io_rdata_q <= 8'h00;
      end else if (io_rd) begin
         io_rdata_q <= rd_val;
      end
   end

   assign lk.hold = cfg_a_q[rtc_pkg::CA_HOLD];
   assign lk.key_bo_en = cfg_a_q[rtc_pkg::CA_KBE];
   assign lk.bo_dis = cfg_a_q[rtc_pkg::CA_BOD];
   assign lk.slip_lim = cfg_a_q[rtc_pkg::CA_LIM +: 2];
   assign lk.ud_en = cfg_b_q[rtc_pkg::CB_UDE];
   assign lk.bo_len = cfg_b_q[rtc_pkg::CB_BOL +: 3];
   assign lk.lk_len = cfg_b_q[rtc_pkg::CB_LKL +: 3];
   assign lk.tx_en = tx_enable_q;
   assign lk.key = carrier_key_q;
   assign lk.ref_tick = filt_q[0] & ~filt_prev_q[0];
   assign lk.slip_tick = filt_q[1] & ~filt_prev_q[1];

   rtc_lock_mon i_rtc_lock_mon (
      .clock(clock),
      .arst_n(arst_n),
      .lk(lk)
   );

   sequence s_key_rise;
      lk.key_bo_en && lk.key && !$past(lk.key);
   endsequence

   sequence s_tx_write;
      io_wr && io_addr == rtc_pkg::OFF_TX;
   endsequence

   a_hold_stops_count: assert property (@(posedge clock) disable iff (!arst_n)
      lk.hold |=> !lk.bo_done && i_rtc_lock_mon.slip_cnt_q == 3'h0)
      else $error("unlock counter ran while hold was set");

   a_key_blackout: assert property (@(posedge clock) disable iff (!arst_n)
      s_key_rise and !lk.bo_dis |-> !lk.count_ok ##1 !lk.bo_done)
      else $error("key rise did not open a blackout");

   a_bod_immediate: assert property (@(posedge clock) disable iff (!arst_n)
      lk.bo_dis && lk.ud_en && lk.lock && lk.slip_tick && !i_rtc_lock_mon.bo_rst
      |=> i_rtc_lock_mon.slip_cnt_q != 3'h0 || !lk.lock)
      else $error("slips not counted with blackout disabled");

   a_slip_single: assert property (@(posedge clock) disable iff (!arst_n)
      lk.count_ok && lk.slip_tick && lk.slip_lim == 2'h0 && lk.lock
      |=> !lk.lock ##1 (!lock_ind_q || cfg_b_q[rtc_pkg::CB_FORCE]))
      else $error("single slip limit did not drop lock");

   a_blackout_ignore: assert property (@(posedge clock) disable iff (!arst_n)
      lk.lock && lk.slip_tick && !lk.bo_dis && !lk.bo_done && lk.tx_en
      |=> lk.lock)
      else $error("slip during blackout affected lock");

   a_tx_on_write: assert property (@(posedge clock) disable iff (!arst_n)
      s_tx_write |=> tx_enable_q == $past(io_wdata[rtc_pkg::TX_ON]))
      else $error("transmitter_on not taken from write");

   a_key_or: assert property (@(posedge clock) disable iff (!arst_n)
      s_tx_write ##1 1'b1 |=> carrier_key_q == ($past(io_wdata[rtc_pkg::TX_KEY], 2)
                                                | $past(bit_timer_key)))
      else $error("carrier key is not manual key OR timer");

   a_lock_readback: assert property (@(posedge clock) disable iff (!arst_n)
      io_rd && io_addr == rtc_pkg::OFF_TX
      |=> io_rdata_q[rtc_pkg::TX_LOCK] == $past(lock_ind_q))
      else $error("lock bit read back wrong");

   a_atten_sum: assert property (@(posedge clock) disable iff (!arst_n)
      io_wr && io_addr == rtc_pkg::OFF_ATT && io_wdata == 8'h13
      |=> ##1 atten_db_q == 6'h0F)
      else $error("attenuation is not coarse plus fine");

   a_vco_trim: assert property (@(posedge clock) disable iff (!arst_n)
      io_wr && io_addr == rtc_pkg::OFF_VCO
      |=> vco_cap_q == $past(io_wdata[4:0]) && io_rdata_q == $past(io_rdata_q))
      else $error("vco capacitor code not stored");

   a_bit_set: assert property (@(posedge clock) disable iff (!arst_n)
      io_bit_set && !io_wr && io_addr == rtc_pkg::OFF_ATT && io_bit_idx == 3'h1
      |=> att_q[1])
      else $error("bit set did not reach register");

   a_unmapped_read: assert property (@(posedge clock) disable iff (!arst_n)
      io_rd && io_addr == 6'h11 |=> io_rdata_q == 8'h00)
      else $error("unmapped address read nonzero");

   a_tx_off_unlock: assert property (@(posedge clock) disable iff (!arst_n)
      !lk.tx_en |=> !lk.lock)
      else $error("lock held with transmitter off");

   a_lock_mirror: assert property (@(posedge clock) disable iff (!arst_n)
      !cfg_b_q[rtc_pkg::CB_FORCE] |=> lock_ind_q == $past(lk.lock))
      else $error("lock indication does not follow monitor");
endmodule // rtc_tx_regs

// ### verif/rf_transmitter_control_regs_test.sv
/*
 Self-checking bench for the transmitter control register bank and lock monitor.
 Assumes the design asserts its own properties; the bench drives the I/O port and pins.
*/
module rf_transmitter_control_regs_test;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct {
      string nm;
      logic [7:0] exp;
      int src;
   } rtc_note_type;

   logic clock = 1'b0;
   logic arst_n;
   logic [5:0] io_addr;
   logic io_wr, io_rd, io_bit_set, io_bit_clr;
   logic [7:0] io_wdata;
   logic [2:0] io_bit_idx;
   logic [7:0] io_rdata_q;
   logic ref_clk_pin, slip_pin, bit_timer_key;
   logic [1:0] vco_window_pin;
   logic tx_enable_q, carrier_key_q, lock_ind_q;
   logic [5:0] atten_db_q;
   logic [4:0] vco_cap_q;
   rtc_note_type notes[$];
   logic rd_seen = 1'b0;
   logic look = 1'b0;
   int n_errors = 0;
   int n_compared = 0;
   int cyc = 0;

   always #25 clock = ~clock;

   rtc_tx_regs i_rtc_tx_regs (
      .clock(clock), .arst_n(arst_n),
      .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
      .io_bit_set(io_bit_set), .io_bit_clr(io_bit_clr), .io_bit_idx(io_bit_idx),
      .io_rdata_q(io_rdata_q), .ref_clk_pin(ref_clk_pin), .slip_pin(slip_pin),
      .vco_window_pin(vco_window_pin), .bit_timer_key(bit_timer_key),
      .tx_enable_q(tx_enable_q), .carrier_key_q(carrier_key_q),
      .atten_db_q(atten_db_q), .vco_cap_q(vco_cap_q), .lock_ind_q(lock_ind_q)
   );

   task automatic give_verdict();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] seen);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   function automatic logic [7:0] pick(input int s);
      case (s)
         0: return io_rdata_q;
         1: return {7'h00, tx_enable_q};
         2: return {7'h00, carrier_key_q};
         3: return {2'h0, atten_db_q};
         4: return {3'h0, vco_cap_q};
         default: return {7'h00, lock_ind_q};
      endcase
   endfunction

   task automatic take();
      rtc_note_type n;
      n = notes.pop_front();
      check(n.nm, n.exp, pick(n.src));
   endtask

   // Read data lands at the edge that samples io_rd; compare on the following falling edge
   always @(posedge clock) rd_seen <= io_rd;

   always @(negedge clock) begin
      if (rd_seen && notes.size() > 0)
         take();
      if (look && notes.size() > 0)
         take();
      look = 1'b0;
   end

   // Cut a hang short well beyond the expected run length
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         give_verdict();
      end
   end

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clock);
      #5;
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(posedge clock);
      #5;
      io_wr = 1'b0;
   endtask

   task automatic bop(input logic [5:0] a, input logic [2:0] i, input bit set);
      @(posedge clock);
      #5;
      io_addr = a;
      io_bit_idx = i;
      io_bit_set = set;
      io_bit_clr = !set;
      @(posedge clock);
      #5;
      io_bit_set = 1'b0;
      io_bit_clr = 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, input logic [7:0] e, input string nm);
      @(posedge clock);
      #5;
      io_addr = a;
      io_rd = 1'b1;
      notes.push_back('{nm, e, 0});
      @(posedge clock);
      #5;
      io_rd = 1'b0;
      @(negedge clock);
      #1;
   endtask

   // Outputs are registered, so let one more edge land before looking
   task automatic probe(input int s, input logic [7:0] e, input string nm);
      @(posedge clock);
      #5;
      notes.push_back('{nm, e, s});
      look = 1'b1;
      @(negedge clock);
      #1;
   endtask

   // Pin pulses stay high 3 and low 7 clocks, wider than the synchroniser needs
   task automatic pulse(input bit s, input int n);
      repeat (n) begin
         @(posedge clock);
         #5;
         if (s)
            slip_pin = 1'b1;
         else
            ref_clk_pin = 1'b1;
         repeat (3) @(posedge clock);
         #5;
         slip_pin = 1'b0;
         ref_clk_pin = 1'b0;
         repeat (6) @(posedge clock);
      end
   endtask

   initial begin
      logic [7:0] d;
      logic [2:0] c, f;
      d = $urandom(48);
      arst_n = 1'b0;
      io_addr = 6'h00;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'h00;
      io_bit_set = 1'b0;
      io_bit_clr = 1'b0;
      io_bit_idx = 3'h0;
      ref_clk_pin = 1'b0;
      slip_pin = 1'b0;
      bit_timer_key = 1'b0;
      vco_window_pin = 2'($urandom % 3);
      repeat (10) @(posedge clock);
      #5;
      arst_n = 1'b1;
      rd(rtc_pkg::OFF_CFG_A, rtc_pkg::RST_CFG_A, "cfg_a reset");
      rd(rtc_pkg::OFF_TX, 8'h00, "tx reset");
      rd(rtc_pkg::OFF_ATT, 8'h00, "atten reset");
      rd(rtc_pkg::OFF_VCO, {vco_window_pin, 6'h00}, "vco reset");
      rd(rtc_pkg::OFF_CFG_B, 8'h00, "cfg_b reset");
      rd(6'h11, 8'h00, "unmapped read");
      wr(rtc_pkg::OFF_CFG_A, 8'hFF);
      rd(rtc_pkg::OFF_CFG_A, 8'h1F, "cfg_a reserved");
      wr(rtc_pkg::OFF_CFG_A, 8'h00);
      d = 8'($urandom);
      wr(rtc_pkg::OFF_VCO, d);
      rd(rtc_pkg::OFF_VCO, {vco_window_pin, d[5:0]}, "vco readback");
      probe(4, {3'h0, d[4:0]}, "vco cap");
      wr(6'h13, 8'hFF);
      rd(rtc_pkg::OFF_TX, 8'h00, "unmapped write");
      for (int k = 0; k < 6; k++) begin
         c = (k == 0) ? 3'h2 : (k == 1) ? 3'h5 : 3'($urandom % 6);
         f = (k == 0) ? 3'h3 : (k == 1) ? 3'h5 : 3'($urandom % 6);
         wr(rtc_pkg::OFF_ATT, {2'h0, c, f});
         repeat (2) @(posedge clock);
         probe(3, {5'h00, c} * 8'h06 + {5'h00, f}, "atten sum");
      end
      wr(rtc_pkg::OFF_ATT, 8'h08);
      bop(rtc_pkg::OFF_ATT, 3'h1, 1'b1);
      probe(3, 8'h08, "atten bit set");
      wr(rtc_pkg::OFF_TX, 8'h24);
      probe(1, 8'h01, "tx on");
      rd(rtc_pkg::OFF_TX, 8'h20, "lock bit read-only");
      bop(rtc_pkg::OFF_CFG_B, 3'h7, 1'b1);
      pulse(1'b0, 7);
      probe(5, 8'h00, "lock after 7");
      pulse(1'b0, 1);
      probe(5, 8'h01, "lock after 8");
      // Keying starts only once lock is shown
      bop(rtc_pkg::OFF_TX, 3'h4, 1'b1);
      probe(2, 8'h01, "manual key set");
      bop(rtc_pkg::OFF_TX, 3'h4, 1'b0);
      probe(2, 8'h00, "manual key clear");
      @(posedge clock);
      #5;
      bit_timer_key = 1'b1;
      probe(2, 8'h01, "timer key");
      @(posedge clock);
      #5;
      bit_timer_key = 1'b0;
      rd(rtc_pkg::OFF_TX, 8'h24, "lock bit");
      // Blackout off, second slip drops lock
      wr(rtc_pkg::OFF_CFG_A, 8'h05);
      pulse(1'b1, 1);
      probe(5, 8'h01, "one slip of two");
      pulse(1'b1, 1);
      probe(5, 8'h00, "second slip");
      pulse(1'b0, 7);
      probe(5, 8'h00, "relock pending");
      pulse(1'b0, 1);
      probe(5, 8'h01, "relock");
      wr(rtc_pkg::OFF_CFG_A, 8'h14);
      pulse(1'b1, 2);
      probe(5, 8'h01, "hold blocks slips");
      wr(rtc_pkg::OFF_TX, 8'h00);
      probe(1, 8'h00, "tx off");
      probe(5, 8'h00, "tx off drops lock");
      wr(rtc_pkg::OFF_TX, 8'h20);
      pulse(1'b0, 8);
      probe(5, 8'h01, "lock again");
      // Key rise opens a blackout of 8 reference clocks
      wr(rtc_pkg::OFF_CFG_A, 8'h08);
      bop(rtc_pkg::OFF_TX, 3'h4, 1'b1);
      pulse(1'b0, 7);
      pulse(1'b1, 1);
      probe(5, 8'h01, "slip in blackout");
      pulse(1'b0, 1);
      pulse(1'b1, 1);
      probe(5, 8'h00, "slip after blackout");
      bop(rtc_pkg::OFF_CFG_B, 3'h6, 1'b1);
      probe(5, 8'h01, "lock forced");
      bop(rtc_pkg::OFF_CFG_B, 3'h6, 1'b0);
      probe(5, 8'h00, "force released");
      give_verdict();
   end
endmodule // rf_transmitter_control_regs_test
